/* File: hdl/dge_gpio_top.v */
// dual-edge pin logic between the core and one bidirectional pad
// assumes register clocks, core data and pad input are synchronous to
// core_clk; the pad wire itself is resolved outside from pad_o and pad_oe
//
// Contract
// - single-edge input appears on rx bit 0; dual-edge puts the rising sample on bit 0 and the falling sample on bit 1.
// - single-edge output drives tx bit 0; dual-edge launches bit 0 on the rising edge and bit 1 on the falling edge.
// - with no input register the pad feeds a bypass output routed to one of four reference or global nets.
// - the core output enable gates the pad driver and may pass through a register first.
// - output data and output-enable registers are timed by the transmit register clock.
// - input capture registers are timed by the separate receive register clock.
// - dual-edge mode samples or launches on both edges; transmit and resync input exchange a two-bit word per clock cycle, normal input one per edge.
// - normal dual-edge mode passes each bit on the very edge it was captured or launched.
// - resync dual-edge mode moves both bits of a pair to or from the core on the rising edge only.
// - in resync input mode the falling sample is held a further half period to emerge with the rising sample.
// - pins that borrow differential resources never use dual-edge capture or launch.
// - every register may trigger on either the rising or the falling edge of its clock.
// - input and output paths are chosen registered or unregistered independently.
// - dual-edge output serialises the two bits onto the pad at twice the clock rate.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "dge_map.vh"

module dge_gpio_top (
    // clock and reset
    input  wire                    core_clk,
    input  wire                    rstn,
    // apb slave
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [`DGE_ADDR_W-1:0]  paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output reg                     pready,
    output reg                     pslverr,
    // register clocks from the core clock tree
    input  wire                    rx_reg_clock,
    input  wire                    tx_reg_clock,
    // transmit side from the core
    input  wire                    tx_rise_bit,
    input  wire                    tx_fall_bit,
    input  wire                    core_oe,
    // receive side to the core
    output wire                    rx_rise_bit,
    output wire                    rx_fall_bit,
    output wire                    rx_valid,
    input  wire                    rx_ready,
    // unregistered bypass feeds
    output reg                     bypass_feed,
    output wire                    global_clock_net,
    output wire                    global_control_net,
    output wire                    synth_ref_clock,
    output wire                    camera_link_ref_clock,
    // pad
    input  wire                    pad_i,
    output reg                     pad_o,
    output reg                     pad_oe
);

    // configuration and status state
    reg  [`DGE_CTL_W-1:0]       ctrl_r;
    reg                         ovf_r;
    // register clock edge detection
    reg                         rxc_q_r;
    reg                         rxc_d_r;
    reg                         txc_q_r;
    reg                         txc_d_r;
    // input capture state
    reg                         pad_q_r;
    reg                         pad_last_r;
    reg                         hi_cap_r;
    reg                         lo_cap_r;
    // output launch state
    reg                         out_lo_r;
    reg                         ser_r;
    reg                         oe_r;
    // bypass routing
    reg  [`DGE_BYP_NETS-1:0]    byp_net_r;
    // combinational terms
    reg                         push_nxt;
    reg  [`DGE_WORD_W-1:0]      word_nxt;
    wire                        in_reg;
    wire                        out_reg;
    wire                        oe_reg;
    wire                        dual_ok;
    wire                        resync;
    wire                        rx_rise_ev;
    wire                        rx_fall_ev;
    wire                        tx_rise_ev;
    wire                        tx_fall_ev;
    wire                        in_edge;
    wire                        out_edge;
    wire                        oe_edge;
    wire                        buf_ready;
    wire [`DGE_BUF_CNT_W-1:0]   buf_level;
    wire [`DGE_BYP_W-1:0]       byp_sel;
    wire                        apb_setup;
    wire                        apb_write;
    wire                        ovf_set;
    wire                        ovf_clr;

    // configuration fields
    assign in_reg  = ctrl_r[`DGE_CTL_IN_REG];
    assign out_reg = ctrl_r[`DGE_CTL_OUT_REG];
    assign oe_reg  = ctrl_r[`DGE_CTL_OE_REG];
    assign resync  = ctrl_r[`DGE_CTL_RESYNC];
    assign byp_sel = ctrl_r[`DGE_CTL_BYP_HI:`DGE_CTL_BYP_LO];
    // a differential-resource pin silently falls back to single edge
    assign dual_ok = ctrl_r[`DGE_CTL_DUAL] & ~ctrl_r[`DGE_CTL_DIFF_PIN];

    // register clocks are sampled, so their edges become one-cycle events
    assign rx_rise_ev = rxc_q_r & ~rxc_d_r;
    assign rx_fall_ev = ~rxc_q_r & rxc_d_r;
    assign tx_rise_ev = txc_q_r & ~txc_d_r;
    assign tx_fall_ev = ~txc_q_r & txc_d_r;

    // per-register trigger edge choice
    assign in_edge  = ctrl_r[`DGE_CTL_IN_FALL] ? rx_fall_ev : rx_rise_ev;
    assign out_edge = ctrl_r[`DGE_CTL_OUT_FALL] ? tx_fall_ev : tx_rise_ev;
    assign oe_edge  = ctrl_r[`DGE_CTL_OE_FALL] ? tx_fall_ev : tx_rise_ev;

    // clock edge and pad sampling; pad_q_r lines up with the edge events
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rxc_q_r <= 1'b0;
            rxc_d_r <= 1'b0;
            txc_q_r <= 1'b0;
            txc_d_r <= 1'b0;
            pad_q_r <= 1'b0;
        end else begin
            rxc_q_r <= rx_reg_clock;
            rxc_d_r <= rxc_q_r;
            txc_q_r <= tx_reg_clock;
            txc_d_r <= txc_q_r;
            pad_q_r <= pad_i;
        end
    end

    // receive word selection per mode
    always @* begin
        push_nxt = 1'b0;
        word_nxt = {`DGE_WORD_W{1'b0}};
        if (!in_reg) begin
            // unregistered: forward only changes, so a steady pad pushes no words
            push_nxt = (pad_q_r != pad_last_r);
            word_nxt = {1'b0, pad_q_r};
        end else if (dual_ok) begin
            if (resync) begin
                // falling sample held since the last fall joins the rise
                push_nxt = rx_rise_ev;
                word_nxt = {lo_cap_r, pad_q_r};
            end else if (rx_rise_ev) begin
                push_nxt = 1'b1;
                word_nxt = {lo_cap_r, pad_q_r};
            end else if (rx_fall_ev) begin
                push_nxt = 1'b1;
                word_nxt = {pad_q_r, hi_cap_r};
            end
        end else begin
            push_nxt = in_edge;
            word_nxt = {1'b0, pad_q_r};
        end
    end

    // lane capture registers on the receive clock
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hi_cap_r   <= 1'b0;
            lo_cap_r   <= 1'b0;
            pad_last_r <= 1'b0;
        end else begin
            pad_last_r <= pad_q_r;
            if (dual_ok && rx_rise_ev) begin
                hi_cap_r <= pad_q_r;
            end
            if (dual_ok && rx_fall_ev) begin
                lo_cap_r <= pad_q_r;
            end
        end
    end

    // a stalled reader keeps two words; a third word is flagged as lost
    dge_buf2 #(
        .WIDTH      (`DGE_WORD_W)
    ) u_rx_buf (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .in_valid   (push_nxt),
        .in_ready   (buf_ready),
        .in_data    (word_nxt),
        .out_valid  (rx_valid),
        .out_ready  (rx_ready),
        .out_data   ({rx_fall_bit, rx_rise_bit}),
        .level      (buf_level)
    );

    // transmit launch: ser_r is the bit currently meant for the pad
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            out_lo_r <= 1'b0;
            ser_r    <= 1'b0;
        end else begin
            if (!out_reg) begin
                ser_r <= tx_rise_bit;
            end else if (dual_ok) begin
                if (tx_rise_ev) begin
                    ser_r <= tx_rise_bit;
                    if (resync) begin
                        // both bits taken together on the rising edge
                        out_lo_r <= tx_fall_bit;
                    end
                end else if (tx_fall_ev) begin
                    if (resync) begin
                        ser_r <= out_lo_r;
                    end else begin
                        // normal mode takes the low lane on its own edge
                        ser_r <= tx_fall_bit;
                    end
                end
            end else if (out_edge) begin
                ser_r <= tx_rise_bit;
            end
        end
    end

    // output enable, registered on the transmit clock or passed straight
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            oe_r <= 1'b0;
        end else if (!oe_reg) begin
            oe_r <= core_oe;
        end else if (oe_edge) begin
            oe_r <= core_oe;
        end
    end

    // pad driver; value parked low while undriven to avoid toggling noise
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pad_o  <= 1'b0;
            pad_oe <= 1'b0;
        end else begin
            pad_oe <= oe_r;
            if (!oe_r) begin
                pad_o <= 1'b0;
            end else if (out_reg && ctrl_r[`DGE_CTL_INVERT]) begin
                pad_o <= ~ser_r;
            end else begin
                pad_o <= ser_r;
            end
        end
    end

    // bypass nets: only live while the input path is unregistered
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bypass_feed <= 1'b0;
        end else begin
            bypass_feed <= ~in_reg & pad_q_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `DGE_BYP_NETS; gi = gi + 1) begin : g_byp
            localparam [`DGE_BYP_W-1:0] SEL = gi;
            // each destination net sees the pad only when selected
            always @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    byp_net_r[gi] <= 1'b0;
                end else begin
                    byp_net_r[gi] <= ~in_reg & pad_q_r &
                                     (byp_sel == SEL);
                end
            end
        end
    endgenerate

    assign global_clock_net      = byp_net_r[0];
    assign global_control_net    = byp_net_r[1];
    assign synth_ref_clock       = byp_net_r[2];
    assign camera_link_ref_clock = byp_net_r[3];

    // apb phases: answer is prepared in setup, pready high in access
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pwrite & pready;

    // lost-word flag: a new loss wins over a clear in the same cycle
    assign ovf_set = push_nxt & ~buf_ready;
    assign ovf_clr = apb_write && !pslverr && (paddr == `DGE_ADDR_STAT) &&
                     pwdata[`DGE_STA_OVF];

    // control register write
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= `DGE_CTL_RESET;
        end else if (apb_write && !pslverr &&
                     (paddr == `DGE_ADDR_CTRL)) begin
            ctrl_r <= pwdata[`DGE_CTL_W-1:0];
        end
    end

    // sticky overflow flag
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ovf_r <= 1'b0;
        end else if (ovf_set) begin
            ovf_r <= 1'b1;
        end else if (ovf_clr) begin
            ovf_r <= 1'b0;
        end
    end

    // apb answer: one wait-free access phase, read data from setup
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata  <= `DGE_DATA_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_setup;
            pslverr <= 1'b0;
            if (apb_setup) begin
                prdata <= `DGE_DATA_ZERO;
                if (paddr == `DGE_ADDR_CTRL) begin
                    prdata[`DGE_CTL_W-1:0] <= ctrl_r;
                end else if (paddr == `DGE_ADDR_STAT) begin
                    prdata[`DGE_STA_PAD] <= pad_q_r;
                    prdata[`DGE_STA_OE]  <= oe_r;
                    prdata[`DGE_STA_OVF] <= ovf_r;
                    prdata[`DGE_STA_LVL_HI:`DGE_STA_LVL_LO] <= buf_level;
                end else begin
                    // unmapped address: error, reads zero, writes dropped
                    pslverr <= 1'b1;
                end
            end
        end
    end

endmodule

/* File: pkg/dge_map.vh */
// register map, field positions and reset values of the dual-edge pin logic
// assumes a 32-bit apb slave with byte addresses and word-aligned registers
`ifndef DGE_MAP_VH
`define DGE_MAP_VH

// apb decode
`define DGE_ADDR_W        8
`define DGE_ADDR_CTRL     8'h00
`define DGE_ADDR_STAT     8'h04
`define DGE_DATA_ZERO     32'h00000000

// control register fields
`define DGE_CTL_IN_REG    0
`define DGE_CTL_OUT_REG   1
`define DGE_CTL_OE_REG    2
`define DGE_CTL_DUAL      3
`define DGE_CTL_RESYNC    4
`define DGE_CTL_IN_FALL   5
`define DGE_CTL_OUT_FALL  6
`define DGE_CTL_OE_FALL   7
`define DGE_CTL_INVERT    8
`define DGE_CTL_DIFF_PIN  9
`define DGE_CTL_BYP_LO    10
`define DGE_CTL_BYP_HI    11
`define DGE_CTL_W         12
`define DGE_CTL_RESET     12'h000

// status register fields
`define DGE_STA_PAD       0
`define DGE_STA_OE        1
`define DGE_STA_OVF       2
`define DGE_STA_LVL_LO    4
`define DGE_STA_LVL_HI    5

// bypass destinations
`define DGE_BYP_NETS      4
`define DGE_BYP_W         2

// receive word and buffer
`define DGE_WORD_W        2
`define DGE_BUF_CNT_W     2
`define DGE_BUF_EMPTY     2'h0
`define DGE_BUF_ONE       2'h1
`define DGE_BUF_FULL      2'h2

`endif

/* File: hdl/dge_buf2.v */
// two-entry receive buffer with valid and ready on both sides
// assumes one clock; head entry and valid come straight from flops
`timescale 1ns/1ps
`include "dge_map.vh"

module dge_buf2 #(
    parameter WIDTH = `DGE_WORD_W
) (
    // clock and reset
    input  wire                      core_clk,
    input  wire                      rstn,
    // filling side
    input  wire                      in_valid,
    output wire                      in_ready,
    input  wire [WIDTH-1:0]          in_data,
    // draining side
    output reg                       out_valid,
    input  wire                      out_ready,
    output reg  [WIDTH-1:0]          out_data,
    // fill level
    output reg  [`DGE_BUF_CNT_W-1:0] level
);

    reg  [WIDTH-1:0]          tail_r;
    reg  [`DGE_BUF_CNT_W-1:0] level_nxt;
    wire                      push;
    wire                      pop;

    // full is honest: a stalled reader lets it fill and refuse
    assign in_ready = (level != `DGE_BUF_FULL);
    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;

    // next fill level
    always @* begin
        level_nxt = level;
        if (push & ~pop) begin
            level_nxt = level + `DGE_BUF_ONE;
        end else if (pop & ~push) begin
            level_nxt = level - `DGE_BUF_ONE;
        end
    end

    // head shifts forward on a pop so out_data stays a register
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            out_data  <= {WIDTH{1'b0}};
            tail_r    <= {WIDTH{1'b0}};
            level     <= `DGE_BUF_EMPTY;
            out_valid <= 1'b0;
        end else begin
            if (push & pop) begin
                if (level == `DGE_BUF_ONE) begin
                    out_data <= in_data;
                end else begin
                    out_data <= tail_r;
                    tail_r   <= in_data;
                end
            end else if (push) begin
                if (level == `DGE_BUF_EMPTY) begin
                    out_data <= in_data;
                end else begin
                    tail_r <= in_data;
                end
            end else if (pop) begin
                out_data <= tail_r;
            end
            level     <= level_nxt;
            out_valid <= (level_nxt != `DGE_BUF_EMPTY);
        end
    end

endmodule

/* File: sim/dge_gpio_props.sv */
// port-level checks for the dual-edge pin logic
// assumes one clock, core_clk, and asynchronous active-low rstn
`timescale 1ns/1ps
`include "dge_map.vh"

module dge_gpio_props (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   rstn,
    // apb slave
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`DGE_ADDR_W-1:0] paddr,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // receive side
    input wire logic                   rx_rise_bit,
    input wire logic                   rx_fall_bit,
    input wire logic                   rx_valid,
    input wire logic                   rx_ready,
    // bypass nets and pad
    input wire logic                   global_clock_net,
    input wire logic                   global_control_net,
    input wire logic                   synth_ref_clock,
    input wire logic                   camera_link_ref_clock,
    input wire logic                   pad_o,
    input wire logic                   pad_oe
);
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // bus answers one cycle after setup; refused reads give zero
    a_setup_gets_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_error_reads_zero: assert property (pslverr && !pwrite |->
        prdata == 32'h00000000)
        else $error("refused read not zero");
    // spare register bits read as zero
    a_ctrl_upper_zero: assert property (pready && !pwrite &&
        paddr == `DGE_ADDR_CTRL |-> prdata[31:12] == 20'h00000)
        else $error("control spare bits set");
    a_stat_spare_zero: assert property (pready && !pwrite &&
        paddr == `DGE_ADDR_STAT |-> {prdata[31:6], prdata[3]} == 27'h0)
        else $error("status spare bits set");
    // no value on the pad while the driver is off
    a_pad_off_quiet: assert property (!pad_oe |-> !pad_o)
        else $error("pad value without enable");
    // a stalled word stays put until taken
    a_rx_word_holds: assert property (rx_valid && !rx_ready |=>
        rx_valid && $stable({rx_fall_bit, rx_rise_bit}))
        else $error("stalled word changed");
    // the bypass reaches one destination at most
    a_bypass_one_net: assert property ($onehot0({global_clock_net,
        global_control_net, synth_ref_clock, camera_link_ref_clock}))
        else $error("bypass on several nets");
endmodule

bind dge_gpio_top dge_gpio_props chk_u (.*);

/* File: sim/dge_pad_model.sv */
// board signal on the pad, resolving the wire from both drivers
// assumes the pin drives pad_o whenever pad_oe is high
`timescale 1ns/1ps

module dge_pad_model (
    // pin side
    input  wire logic pad_o,
    input  wire logic pad_oe,
    // board side
    input  wire logic ext_drive,
    input  wire logic ext_val,
    // resolved level
    output wire logic pad_i
);
    // pin wins while driving; weak pull-up keeps an idle wire at 1
    assign pad_i = pad_oe ? pad_o : (ext_drive ? ext_val : 1'b1);
endmodule

/* File: sim/tb.sv */
// self-checking bench for the dual-edge pin logic
// assumes the bound checker and the pad model are compiled alongside
`timescale 1ns/1ps
`include "dge_map.vh"
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
end

module tb;
    // control words from the field positions
    localparam [31:0] INR  = 32'h1 << `DGE_CTL_IN_REG;
    localparam [31:0] OUTR = 32'h1 << `DGE_CTL_OUT_REG;
    localparam [31:0] OER  = 32'h1 << `DGE_CTL_OE_REG;
    localparam [31:0] DUAL = 32'h1 << `DGE_CTL_DUAL;
    localparam [31:0] RSY  = 32'h1 << `DGE_CTL_RESYNC;
    localparam [31:0] INV  = 32'h1 << `DGE_CTL_INVERT;
    localparam [31:0] DIFF = 32'h1 << `DGE_CTL_DIFF_PIN;
    // bench signals
    logic        core_clk = 1'b0;
    logic        rstn, psel, penable, pwrite, rx_reg_clock, tx_reg_clock;
    logic        tx_rise_bit, tx_fall_bit, core_oe, rx_ready;
    logic        ext_drive, ext_val;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready, pslverr, rx_rise_bit, rx_fall_bit, rx_valid;
    wire         bypass_feed, pad_i, pad_o, pad_oe;
    wire  [3:0]  nets;
    logic [15:0] seed = 16'h085D;
    int          fails = 0, comparisons = 0, cycles = 0;

    dge_gpio_top dut_u (.*, .global_clock_net(nets[0]),
        .global_control_net(nets[1]), .synth_ref_clock(nets[2]),
        .camera_link_ref_clock(nets[3]));
    dge_pad_model pad_u (.*);

    // 250 MHz clock and hang guard
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    // random source and expected receive words
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [1:0] rx_word(input logic dual, f, r);
        return dual ? {f, r} : {1'b0, r};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (n == 20) fails++;
    endtask
    task automatic wr(input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, `DGE_ADDR_CTRL, d, r, e);
    endtask
    // register clock half periods of 8 core cycles
    task automatic txe(input logic lvl);
        @(posedge core_clk);
        tx_reg_clock <= lvl;
        step(7);
    endtask
    task automatic rxe(input logic lvl, input logic p);
        @(posedge core_clk);
        {rx_reg_clock, ext_val} <= {lvl, p};
        step(7);
    endtask
    // take the head word; ready is raised for exactly one edge
    task automatic pop(output logic [1:0] w);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (rx_valid !== 1'b1 && n < 40);
        `CHK(rx_valid, 1'b1)
        w = {rx_fall_bit, rx_rise_bit};
        @(posedge core_clk);
        rx_ready <= 1'b1;
        @(posedge core_clk);
        rx_ready <= 1'b0;
    endtask
    task automatic flush;
        logic [1:0] w;
        repeat (3) begin
            @(negedge core_clk);
            if (rx_valid === 1'b1) pop(w);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] r;
        logic        e;
        logic [1:0]  w;
        logic [3:0]  v;
        int          s;
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        {rx_reg_clock, tx_reg_clock, tx_rise_bit, tx_fall_bit} = '0;
        {core_oe, rx_ready, ext_drive, ext_val} = '0;
        step(4);
        rstn <= 1'b1;
        // reset value, refused places, random readback
        apb(1'b0, `DGE_ADDR_CTRL, 32'h0, r, e);
        `CHK(r, 32'h00000000)
        apb(1'b0, 8'h08, 32'h0, r, e);
        `CHK({e, r}, {1'b1, 32'h00000000})
        apb(1'b1, 8'h0C, 32'hFFF, r, e);
        `CHK(e, 1'b1)
        repeat (3) begin
            seed = lfsr(seed);
            wr({16'h0000, seed});
            apb(1'b0, `DGE_ADDR_CTRL, 32'h0, r, e);
            `CHK(r, {20'h00000, seed[11:0]})
        end
        // unregistered drive, then the enable dropped
        wr(32'h0);
        v = seed[7:4];
        {core_oe, tx_rise_bit} <= {1'b1, v[0]};
        step(4);
        @(negedge core_clk);
        `CHK({pad_oe, pad_o}, {1'b1, v[0]})
        step(1);
        core_oe <= 1'b0;
        step(4);
        @(negedge core_clk);
        `CHK({pad_oe, pad_o}, 2'b00)
        // registered and inverted; a core change alone launches nothing
        wr(OUTR | OER | INV);
        {core_oe, tx_rise_bit} <= {1'b1, v[1]};
        txe(1'b1);
        @(negedge core_clk);
        `CHK({pad_oe, pad_o}, {1'b1, ~v[1]})
        step(1);
        tx_rise_bit <= ~v[1];
        txe(1'b0);
        @(negedge core_clk);
        `CHK(pad_o, ~v[1])
        // both lanes onto the pad, normal then resync
        for (s = 0; s < 2; s++) begin
            wr(OUTR | OER | DUAL | (s ? RSY : 32'h0));
            {tx_rise_bit, tx_fall_bit} <= {v[s], ~v[s]};
            txe(1'b1);
            @(negedge core_clk);
            `CHK(pad_o, v[s])
            txe(1'b0);
            @(negedge core_clk);
            `CHK(pad_o, ~v[s])
        end
        step(1);
        {core_oe, ext_drive} <= 2'b01;
        // single edge capture; a borrowed pair pin stays single edge
        for (s = 0; s < 2; s++) begin
            wr(s ? INR | DUAL | DIFF : INR);
            flush();
            seed = lfsr(seed);
            v = seed[3:0];
            rxe(1'b1, v[0]);
            rxe(1'b0, v[1]);
            pop(w);
            `CHK(w, rx_word(1'b0, v[1], v[0]))
            @(negedge core_clk);
            `CHK({rx_valid, bypass_feed, nets}, 6'h00)
        end
        // dual capture: a word on each edge, or one per period in resync
        for (s = 0; s < 2; s++) begin
            wr(INR | DUAL | (s ? RSY : 32'h0));
            seed = lfsr(seed);
            v = seed[3:0];
            rxe(1'b1, v[0]);
            rxe(1'b0, v[1]);
            flush();
            rxe(1'b1, v[2]);
            rxe(1'b0, v[3]);
            if (s) rxe(1'b1, seed[5]);
            pop(w);
            `CHK(w, rx_word(1'b1, v[1], v[2]))
            pop(w);
            `CHK(w, rx_word(1'b1, v[3], s ? seed[5] : v[2]))
            @(negedge core_clk);
            `CHK(rx_valid, 1'b0)
            if (s) rxe(1'b0, v[3]);
        end
        // stalled receiver: third word refused and flagged
        wr(INR);
        flush();
        seed = lfsr(seed);
        v = seed[3:0];
        for (s = 0; s < 3; s++) begin
            rxe(1'b1, v[s]);
            rxe(1'b0, v[s]);
        end
        apb(1'b0, `DGE_ADDR_STAT, 32'h0, r, e);
        `CHK({r[5:4], r[2]}, 3'h5)
        apb(1'b1, `DGE_ADDR_STAT, 32'h00000004, r, e);
        apb(1'b0, `DGE_ADDR_STAT, 32'h0, r, e);
        `CHK({r[5:4], r[2]}, 3'h4)
        for (s = 0; s < 2; s++) begin
            pop(w);
            `CHK(w, rx_word(1'b0, 1'b0, v[s]))
        end
        // unregistered input routed to each bypass destination
        for (s = 0; s < 4; s++) begin
            wr(32'(s) << `DGE_CTL_BYP_LO);
            ext_val <= 1'b1;
            step(6);
            @(negedge core_clk);
            `CHK({bypass_feed, nets}, {1'b1, 4'h1 << s})
            step(1);
            ext_val <= 1'b0;
            step(6);
            @(negedge core_clk);
            `CHK({bypass_feed, nets}, 5'h00)
        end
        give_verdict();
    end
endmodule
